// [logic/ied_core.v]
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "ied_map.vh"

// Notes on behaviour
// RL1: entry lowers stack pointer by four first
// RL2: then pushes program counter and status
// RL3: entry clears interrupt enable, pending, trace
// RL4: vector doubled plus base fetches entry into counter
// RL5: return pops counter, status, raises pointer four
// RL6: table: 1 nonmask, 5-10 traps, 16+n
// RL7: entry halfword shifted left, zero-extended
// RL8: base is 21 bits, top five, bit0 zero
// RL9: software loads base before using interrupts
// RL10: table holds 48 halfword entries
// RL11: entry address is vector times two plus base
// RL12: software sets stack pointer into ram first
// RL13: falling pin edge traps, synchronised inside
// RL14: nonmask trap disabled until enable set
// RL15: single-shot enable cleared when trap taken
// RL16: locked enable sticks until reset
// RL17: locked enable makes single-shot enable ignored
// RL18: handler re-arms single-shot enable before return
// RL19: vector shows highest enabled pending request
// RL20: request flag set by edge, cleared on read
// RL21: maskable vector equals sixteen plus request
module ied_core #(
  parameter NREQ = 32
) (
  // clock and asynchronous reset
  input wire sys_clk_i,
  input wire rst_i,
  // register port
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // interrupt control unit side
  input wire [NREQ-1:0] irq_pend_i,
  input wire [NREQ-1:0] irq_en_i,
  // current core state and sequence requests
  input wire [15:0] psw_i,
  input wire [20:0] pc_i,
  input wire int_req_i,
  input wire return_from_exception_i,
  // nonmask pin, asynchronous, active low
  input wire nmi_n_i,
  // stack and dispatch table memory port
  output reg mem_wr_o,
  output reg mem_rd_o,
  output reg [20:0] mem_addr_o,
  output reg [15:0] mem_wdata_o,
  input wire [15:0] mem_rdata_i,
  input wire mem_ack_i,
  // register updates handed to the core
  output reg [20:0] pc_o,
  output reg pc_load_o,
  output reg [15:0] psw_o,
  output reg psw_load_o,
  output reg busy_o
);

  // sequencer states
  localparam ST_IDLE = 4'h0;
  localparam ST_DEC = 4'h1;
  localparam ST_PUSH_PC = 4'h2;
  localparam ST_PUSH_PSW = 4'h3;
  localparam ST_FETCH = 4'h4;
  localparam ST_LOAD = 4'h5;
  // return path states
  localparam ST_POP_PC = 4'h6;
  localparam ST_POP_PSW = 4'h7;
  localparam ST_INC = 4'h8;

  // priority encoder: highest enabled pending request, valid in bit 6
  function [6:0] ied_prio;
    input [NREQ-1:0] act;
    integer k;
    begin
      ied_prio = 7'h00;
      // later passes overwrite, so the highest index wins
      for (k = 0; k < NREQ; k = k + 1) begin
        if (act[k]) begin
          ied_prio = {1'b1, `IED_IRQ_OFFSET + k[5:0]};
        end
      end
    end
  endfunction

  reg [20:0] base_q; // dispatch table base
  reg [20:0] isp_q; // interrupt stack pointer
  reg [3:0] st_q; // sequencer state
  reg nmi_s1_q; // synchroniser first stage
  reg nmi_s2_q; // synchroniser second stage
  reg nmi_s3_q; // previous synchronised level
  reg en_q; // single-shot enable
  reg lck_q; // locked enable
  reg ext_q; // external request flag
  reg nmi_pend_q; // nonmask trap waiting for entry
  reg is_nmi_q; // current entry is the nonmask trap
  reg [5:0] vec_q; // latched vector of current entry
  reg [5:0] vreg_q; // vector register
  reg [20:0] pc_hold_q; // popped counter

  wire [6:0] prio = ied_prio(irq_pend_i & irq_en_i);
  wire nmi_fall = nmi_s3_q & ~nmi_s2_q;
  wire nmi_armed = lck_q | en_q; // see RL14
  // a trap fires when an edge meets an armed enable
  wire nmi_take = nmi_fall & nmi_armed; // see RL17
  // register strobes decoded once for the flag logic
  wire rd_stat = rd_i & (addr_i == `IED_REG_NMSTAT);
  wire wr_ctl = wr_i & (addr_i == `IED_REG_NMCTL);
  wire start_nmi = (st_q == ST_IDLE) & (nmi_pend_q | nmi_take);
  // entry address: vector doubled plus base
  wire [20:0] ent_addr = base_q + {14'h0000, vec_q, 1'b0}; // see RL11

  // nonmask pin synchroniser and edge history
  always @(posedge sys_clk_i or posedge rst_i) begin
    // pin idles high, so a high reset gives no false edge
    if (rst_i) begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_s3_q <= 1'b1;
    end else begin
      nmi_s1_q <= nmi_n_i; // see RL13
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  // nonmask enables, request flag and pending trap
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // both enables off out of reset
      en_q <= 1'b0; // see RL14
      lck_q <= 1'b0;
      ext_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      // lock can only be set by software and is cleared only by reset
      if (wr_ctl & wdata_i[`IED_CTL_LCK]) begin
        lck_q <= 1'b1; // see RL16
      end
      // software write, then hardware auto-clear on a taken trap
      if (wr_ctl) begin
        en_q <= wdata_i[`IED_CTL_EN];
      end
      // with the lock set the auto-clear does nothing
      if (nmi_take & ~lck_q) begin
        en_q <= 1'b0; // see RL15
      end
      // set wins over the clear-on-read
      if (nmi_fall) begin
        ext_q <= 1'b1; // see RL20
      end else if (rd_stat) begin
        ext_q <= 1'b0;
      end
      // hold trap until sequencer is free
      if (start_nmi) begin
        nmi_pend_q <= 1'b0;
      end
      if (nmi_take & ~start_nmi) begin
        nmi_pend_q <= 1'b1;
      end
    end
  end

  // vector register tracks highest enabled pending request
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vreg_q <= 6'h00;
    end else if (prio[6]) begin
      vreg_q <= prio[5:0]; // see RL19, RL21
    end else begin
      // nothing enabled and pending reads zero
      vreg_q <= 6'h00;
    end
  end

  // base register written by software; stack pointer is written in the sequencer
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_q <= `IED_BASE_RST;
    end else if (wr_i & (addr_i == `IED_REG_BASE)) begin
      base_q <= wdata_i[20:0] & `IED_BASE_MASK; // see RL8, RL9
    end
  end

  // entry and return sequencer
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      isp_q <= `IED_ISP_RST;
      is_nmi_q <= 1'b0;
      vec_q <= 6'h00;
      pc_hold_q <= 21'h000000;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      // memory port leaves reset with a cleared address
      mem_addr_o <= 21'h000000;
      mem_wdata_o <= 16'h0000;
      pc_o <= 21'h000000;
      pc_load_o <= 1'b0;
      psw_o <= 16'h0000;
      psw_load_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      pc_load_o <= 1'b0;
      psw_load_o <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // stack pointer is software-writable only when idle
          if (wr_i & (addr_i == `IED_REG_ISP)) begin
            isp_q <= wdata_i[20:0]; // see RL12
          end
          // nonmask trap first, then maskable, then return
          if (start_nmi) begin
            is_nmi_q <= 1'b1;
            vec_q <= `IED_NMI_VECTOR; // see RL6
            busy_o <= 1'b1;
            st_q <= ST_DEC;
          end else if (int_req_i) begin
            is_nmi_q <= 1'b0;
            vec_q <= vreg_q; // see RL4
            busy_o <= 1'b1;
            st_q <= ST_DEC;
          end else if (return_from_exception_i) begin
            busy_o <= 1'b1;
            mem_rd_o <= 1'b1;
            mem_addr_o <= isp_q; // see RL5
            st_q <= ST_POP_PC;
          end else begin
            busy_o <= 1'b0;
          end
        end
        ST_DEC: begin
          // lower the pointer first, then push the counter
          isp_q <= isp_q - `IED_STACK_STEP; // see RL1
          mem_wr_o <= 1'b1;
          mem_addr_o <= isp_q - `IED_STACK_STEP; // see RL2
          mem_wdata_o <= pc_i[16:1];
          st_q <= ST_PUSH_PC;
        end
        ST_PUSH_PC: begin
          // counter word taken, status goes one halfword above
          if (mem_ack_i) begin
            mem_addr_o <= isp_q + `IED_PSW_SLOT;
            mem_wdata_o <= psw_i; // see RL2
            st_q <= ST_PUSH_PSW;
          end
        end
        ST_PUSH_PSW: begin
          // status taken: clear the masks, then fetch the entry
          if (mem_ack_i) begin
            mem_wr_o <= 1'b0;
            psw_o <= psw_i;
            psw_o[`IED_PSW_I] <= 1'b0; // see RL3
            psw_o[`IED_PSW_P] <= 1'b0;
            psw_o[`IED_PSW_T] <= 1'b0;
            psw_load_o <= 1'b1;
            // vectors past the table end are not fetched
            if (vec_q < `IED_DISPATCH_LEN) begin
              mem_rd_o <= 1'b1;
              mem_addr_o <= ent_addr; // see RL10, RL11
              st_q <= ST_FETCH;
            end else begin
              busy_o <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_FETCH: begin
          // table entry holds routine address bits 16 to 1
          if (mem_ack_i) begin
            mem_rd_o <= 1'b0;
            pc_o <= {4'h0, mem_rdata_i, 1'b0}; // see RL7
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // hand the routine address to the core
          pc_load_o <= 1'b1; // see RL4
          busy_o <= 1'b0;
          st_q <= ST_IDLE;
        end
        ST_POP_PC: begin
          // counter popped, read the status word above it
          if (mem_ack_i) begin
            pc_hold_q <= {4'h0, mem_rdata_i, 1'b0};
            mem_addr_o <= isp_q + `IED_PSW_SLOT;
            st_q <= ST_POP_PSW;
          end
        end
        ST_POP_PSW: begin
          // status popped, stage both words for loading
          if (mem_ack_i) begin
            mem_rd_o <= 1'b0;
            psw_o <= mem_rdata_i;
            pc_o <= pc_hold_q; // see RL5
            st_q <= ST_INC;
          end
        end
        ST_INC: begin
          // release the frame and load both registers
          isp_q <= isp_q + `IED_STACK_STEP; // see RL5
          pc_load_o <= 1'b1;
          psw_load_o <= 1'b1;
          busy_o <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          // unused state codes fall back to idle
          busy_o <= 1'b0;
          mem_wr_o <= 1'b0;
          mem_rd_o <= 1'b0;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read data, one cycle after the read strobe
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `IED_REG_BASE: rdata_o <= {11'h000, base_q};
        `IED_REG_ISP: rdata_o <= {11'h000, isp_q};
        `IED_REG_PSW: rdata_o <= {16'h0000, psw_o};
        `IED_REG_PC: rdata_o <= {11'h000, pc_o};
        `IED_REG_NMCTL: rdata_o <= {29'h00000000, lck_q, nmi_s2_q, en_q};
        `IED_REG_NMSTAT: rdata_o <= {31'h00000000, ext_q}; // see RL20
        `IED_REG_VECTOR: rdata_o <= {26'h0000000, vreg_q};
        `IED_REG_STATE: rdata_o <= {27'h0000000, is_nmi_q, st_q};
        // unmapped indices read zero
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      // read data stands for one cycle only
      rdata_o <= 32'h00000000;
    end
  end

endmodule // ied_core

// [logic/ied_map.vh]
`ifndef IED_MAP_VH
`define IED_MAP_VH
// register indices on the plain register port
`define IED_REG_BASE     4'h0
`define IED_REG_ISP      4'h1
`define IED_REG_PSW      4'h2
`define IED_REG_PC       4'h3
`define IED_REG_NMCTL    4'h4
`define IED_REG_NMSTAT   4'h5
`define IED_REG_VECTOR   4'h6
`define IED_REG_STATE    4'h7
// field positions in the control register
`define IED_CTL_EN       0
`define IED_CTL_PIN      1
`define IED_CTL_LCK      2
// status word bits cleared on entry
`define IED_PSW_T        1
`define IED_PSW_P        9
`define IED_PSW_I        11
// constants
`define IED_STACK_STEP   21'h000004
`define IED_BASE_MASK    21'h00FFFE
`define IED_PSW_SLOT     21'h000002
// reset values and fixed vector constants
`define IED_BASE_RST     21'h000000
`define IED_ISP_RST      21'h000000
`define IED_NMI_VECTOR   6'h01
`define IED_IRQ_OFFSET   6'h10
`define IED_DISPATCH_LEN 6'h30
`endif

// [verif/ied_core_properties.sv]
`timescale 1ns/10ps
module ied_core_properties #(
  parameter NREQ = 32
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire [20:0] pc_i,
  input wire mem_wr_o,
  input wire mem_rd_o,
  input wire mem_ack_i,
  input wire [20:0] mem_addr_o,
  input wire [15:0] mem_wdata_o,
  input wire [20:0] pc_o,
  input wire pc_load_o,
  input wire [15:0] psw_o,
  input wire psw_load_o,
  input wire busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // one pushed word accepted by memory
  sequence s_word;
    mem_wr_o && mem_ack_i;
  endsequence
  chk_base_mask: assert property (rd_i && addr_i == 4'h0 |=>
    (rdata_o & 32'hFFFF0001) == 32'h0) else $error("base bits");
  chk_push_pc: assert property ($rose(mem_wr_o) |->
    mem_wdata_o == pc_i[16:1]) else $error("pc not pushed first");
  chk_push_step: assert property (s_word ##1 mem_wr_o |->
    mem_addr_o == $past(mem_addr_o) + 21'h2) else $error("push step");
  chk_entry_clear: assert property (psw_load_o && mem_rd_o |->
    (psw_o & 16'h0A02) == 16'h0) else $error("status not cleared");
  chk_route_even: assert property (pc_load_o |->
    !pc_o[0] && !pc_o[20]) else $error("route address form");
  chk_load_pulse: assert property (pc_load_o |=> !pc_load_o)
    else $error("load not a pulse");
  chk_wait_hold: assert property (mem_wr_o && !mem_ack_i |=>
    mem_wr_o && $stable(mem_addr_o)) else $error("write dropped");
  chk_busy_bound: assert property ($rose(busy_o) |->
    ##[1:60] !busy_o) else $error("sequence hangs");
endmodule // ied_core_properties

// [verif/ied_core_tb.sv]
`timescale 1ns/10ps
`include "ied_map.vh"
module ied_core_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] a = 4'h0;
  reg [31:0] wd = 32'h0;
  reg w = 1'b0, r = 1'b0, ir = 1'b0, rx = 1'b0, nmi_n = 1'b1, slow = 1'b1;
  reg [31:0] pend = 32'h28, en = 32'h20; // request 5 wins, 3 masked
  wire [31:0] rdata;
  wire mwr, mrd, ack, busy;
  wire [20:0] maddr, pc;
  wire [15:0] mwd, mrdat, psw;
  integer fails = 0, n_tests = 0;
  ied_core ied_core_i (.sys_clk_i(clk), .rst_i(rst), .addr_i(a),
    .wdata_i(wd), .wr_i(w), .rd_i(r), .rdata_o(rdata), .irq_pend_i(pend),
    .irq_en_i(en), .psw_i(16'hFFFF), .pc_i(21'h01234), .int_req_i(ir),
    .return_from_exception_i(rx), .nmi_n_i(nmi_n), .mem_wr_o(mwr), .mem_rd_o(mrd),
    .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrdat),
    .mem_ack_i(ack), .pc_o(pc), .pc_load_o(), .psw_o(psw),
    .psw_load_o(), .busy_o(busy));
  ied_mem ied_mem_i (.clk_i(clk), .rst_i(rst), .slow_i(slow), .wr_i(mwr),
    .rd_i(mrd), .addr_i(maddr), .wdata_i(mwd), .ack_o(ack),
    .rdata_o(mrdat));
  initial forever #2.5 clk = ~clk;
  task end_of_test;
    begin
      $display("checks %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] x, input [31:0] d);
    begin
      @(posedge clk); a <= x; wd <= d; w <= 1'b1;
      @(posedge clk); w <= 1'b0;
    end
  endtask
  task rd(input [3:0] x, input [31:0] e);
    begin
      @(posedge clk); a <= x; r <= 1'b1;
      @(posedge clk); r <= 1'b0;
      @(negedge clk); chk(rdata, e);
    end
  endtask
  // request pulse when p is set, then wait for the sequence to end
  task go(input k, input p);
    integer i;
    begin
      @(posedge clk); ir <= k & p; rx <= ~k & p;
      @(posedge clk); ir <= 1'b0; rx <= 1'b0;
      for (i = 0; i < 9 && busy !== 1'b1; i = i + 1) @(negedge clk);
      for (i = 0; i < 99 && busy !== 1'b0; i = i + 1) @(negedge clk);
      chk({31'h0, busy}, 0);
    end
  endtask
  task pin(input v);
    begin
      @(posedge clk); nmi_n <= v;
      repeat (4) @(posedge clk);
    end
  endtask
  initial begin
    #20000;
    fails = fails + 1;
    end_of_test;
  end
  initial begin
    ied_mem_i.m[32'h102A] = 16'h4321;
    ied_mem_i.m[32'h1002] = 16'h0100;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`IED_REG_BASE, 0);
    rd(`IED_REG_NMCTL, 32'h2);
    rd(`IED_REG_NMSTAT, 0);
    rd(4'h8, 0);
    $display("reset test done");
    wr(`IED_REG_BASE, 32'hFFFFFFFF);
    rd(`IED_REG_BASE, 32'h00FFFE);
    wr(`IED_REG_BASE, 32'h1000);
    wr(`IED_REG_ISP, 32'h2000);
    rd(`IED_REG_VECTOR, 21);
    go(1, 1);
    rd(`IED_REG_ISP, 32'h1FFC);
    chk(ied_mem_i.m[32'h1FFC], 32'h091A);
    chk(ied_mem_i.m[32'h1FFE], 32'hFFFF);
    rd(`IED_REG_PSW, 32'hF5FD);
    rd(`IED_REG_PC, 32'h08642);
    $display("entry test done");
    go(0, 1);
    slow <= 1'b0;
    rd(`IED_REG_ISP, 32'h2000);
    rd(`IED_REG_PC, 32'h01234);
    rd(`IED_REG_PSW, 32'hFFFF);
    $display("return test done");
    pin(0);
    go(0, 0);
    rd(`IED_REG_ISP, 32'h2000);
    pin(1);
    wr(`IED_REG_NMCTL, 1);
    pin(0);
    go(0, 0);
    rd(`IED_REG_PC, 32'h200);
    rd(`IED_REG_NMCTL, 0);
    rd(`IED_REG_NMSTAT, 1);
    rd(`IED_REG_NMSTAT, 0);
    pin(1);
    pin(0);
    go(0, 0);
    rd(`IED_REG_ISP, 32'h1FFC);
    wr(`IED_REG_NMCTL, 1);
    pin(1);
    pin(0);
    go(0, 0);
    rd(`IED_REG_ISP, 32'h1FF8);
    $display("single shot test done");
    pin(1);
    wr(`IED_REG_NMCTL, 5);
    wr(`IED_REG_NMCTL, 0);
    rd(`IED_REG_NMCTL, 32'h6);
    pin(0);
    go(0, 0);
    rd(`IED_REG_ISP, 32'h1FF4);
    pin(1);
    pin(0);
    go(0, 0);
    rd(`IED_REG_ISP, 32'h1FF0);
    $display("locked test done");
    pin(1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`IED_REG_NMCTL, 32'h2);
    rd(`IED_REG_NMSTAT, 0);
    rd(`IED_REG_ISP, 0);
    $display("mid-run reset test done");
    end_of_test;
  end
endmodule // ied_core_tb
bind ied_core ied_core_properties chk_i (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .addr_i(addr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .pc_i(pc_i),
  .mem_wr_o(mem_wr_o),
  .mem_rd_o(mem_rd_o),
  .mem_ack_i(mem_ack_i),
  .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o),
  .pc_o(pc_o),
  .pc_load_o(pc_load_o),
  .psw_o(psw_o),
  .psw_load_o(psw_load_o),
  .busy_o(busy_o)
);

// [verif/ied_mem.sv]
`timescale 1ns/10ps
module ied_mem (
  input wire clk_i,
  input wire rst_i,
  input wire slow_i,
  input wire wr_i,
  input wire rd_i,
  input wire [20:0] addr_i,
  input wire [15:0] wdata_i,
  output reg ack_o,
  output reg [15:0] rdata_o
);
  reg [15:0] m [0:16383]; // halfwords keyed by byte address
  reg [1:0] wait_q; // wait states served so far
  // answer each word once, after two waits when slow
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      rdata_o <= 16'h0;
    end else if ((wr_i || rd_i) && !ack_o &&
                 (!slow_i || wait_q == 2'h2)) begin
      ack_o <= 1'b1;
      wait_q <= 2'h0;
      if (wr_i) begin
        m[addr_i[13:0]] <= wdata_i;
      end
      rdata_o <= m[addr_i[13:0]];
    end else begin
      ack_o <= 1'b0;
      wait_q <= ((wr_i || rd_i) && !ack_o) ? wait_q + 2'h1 : 2'h0;
      rdata_o <= ~rdata_o; // data never looks valid outside ack
    end
  end
endmodule // ied_mem
